// ---- common/piw_defines.vh ----
// Register map, field positions, reset values and codes for the controller
`ifndef PIW_DEFINES_VH
`define PIW_DEFINES_VH

// ==========================================================
// Register offsets
`define PIW_ADDR_TPIC 8'h88
`define PIW_ADDR_EXFLAG 8'h91
`define PIW_ADDR_WAKEUP_SOURCE_MASK 8'h9F
`define PIW_ADDR_IEMAIN 8'hA8
`define PIW_ADDR_IPMAIN 8'hB8
`define PIW_ADDR_VECCFG 8'hC0
`define PIW_ADDR_STATUS 8'hC5
`define PIW_ADDR_PINCFG 8'hD0
`define PIW_ADDR_IEEXT 8'hE8
`define PIW_ADDR_IPEXT 8'hF8

// ==========================================================
// Reset values
`define PIW_RST_ZERO 8'h00
`define PIW_RST_WAKEUP_SOURCE_MASK 8'hFF

// ==========================================================
// Field positions
`define PIW_TPIC_TF1 7
`define PIW_TPIC_TR1 6
`define PIW_TPIC_TF0 5
`define PIW_TPIC_TR0 4
`define PIW_TPIC_PG1 3
`define PIW_TPIC_PG0 1
`define PIW_IE_GLOBAL 7
`define PIW_STATUS_HIGH 6
`define PIW_STATUS_LOW 5
`define PIW_VECCFG_RELOC 5
`define PIW_PINCFG_RISE 0
`define PIW_PINCFG_FALL 1
`define PIW_PINCFG_GROUP 2

// ==========================================================
// Source identifiers, vectors and levels
`define PIW_ID_PG0 5'd0
`define PIW_ID_TF0 5'd1
`define PIW_ID_PG1 5'd2
`define PIW_ID_TF1 5'd3
`define PIW_ID_DBG 5'd16
`define PIW_ID_BKP 5'd17
`define PIW_ID_NONE 5'd31
`define PIW_VEC_FIRST 8'h03
`define PIW_VEC_DBG 8'hC0
`define PIW_VEC_BKP 8'h80
`define PIW_LVL_LOW 2'd0
`define PIW_LVL_HIGH 2'd1
`define PIW_LVL_DBG 2'd2

`endif

// ---- logic/piw_ctrl.v ----
// Priority interrupt, vector and STOP wake-up controller
`include "piw_defines.vh"

module piw_ctrl #(
  parameter NUM_PINS = 8,
  parameter [7:0] CLOCKLESS_MASK = 8'h0B
) (
  // Clock and reset
  input wire CLK_SYS_I,
  input wire RST_I,
  // Register port
  input wire [7:0] ADDR_I,
  input wire [7:0] WR_DATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [7:0] RD_DATA_O,
  // Peripheral requests
  input wire [NUM_PINS-1:0] GPIO_I,
  input wire TIMER0_OVF_I,
  input wire TIMER1_OVF_I,
  input wire UART1_IRQ_I,
  input wire TIMER2_IRQ_I,
  input wire UART2_IRQ_I,
  input wire I2C_MASTER_EVT_I,
  input wire [6:0] EXT_IRQ_I,
  input wire WATCHDOG_IRQ_I,
  input wire ECC_IRQ_I,
  // Debug requests
  input wire DEBUG_PORT_MODE_I,
  input wire DEBUG_REQ_I,
  input wire DEBUG_ID_MATCH_I,
  input wire BREAKPOINT_MATCH_I,
  // CPU side
  output reg IRQ_REQ_O,
  output reg [15:0] IRQ_VECTOR_O,
  input wire IRQ_ACK_I,
  input wire IRQ_RETURN_I,
  output wire TIMER0_RUN_O,
  output wire TIMER1_RUN_O,
  // Power
  input wire STOP_I,
  output reg OSC_START_O,
  input wire OSC_READY_I,
  output reg CLK_RESUME_O
);

  // ========================================================
  // Functions
  function [4:0] first_set;
    input [15:0] v;
    integer k;
    begin
      first_set = `PIW_ID_NONE;
      for (k = 15; k >= 0; k = k - 1) begin
        if (v[k]) begin
          first_set = k[4:0];
        end
      end
    end
  endfunction

  // ========================================================
  // State
  localparam [2:0] ST_RUN = 3'b001;
  localparam [2:0] ST_OSC = 3'b010;
  localparam [2:0] ST_RES = 3'b100;

  reg [7:0] ie_q, ip_q, irq_enable_extended_q, irq_priority_extended_q, wakeup_source_mask_q, veccfg_q;
  reg tr0_q, tr1_q, tf0_q, tf1_q, pg0f_q, pg1f_q, i2cm_q;
  reg uart1_q, tmr2_q, uart2_q, wdt_q, ecc_q;
  reg [6:0] ext_q, ext_prev_q;
  reg [NUM_PINS-1:0] gpio_q, gpio_prev_q;
  reg [7:0] pincfg_q [0:NUM_PINS-1];
  reg dbg_pend_q, bkp_pend_q;
  reg dbg_is_q, hip_q, lip_q;
  reg [4:0] sel_q;
  reg [1:0] sel_lvl_q;
  reg [2:0] st_q;
  integer i, j, m;

  // Sample every request on the rising edge
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      uart1_q <= 1'b0;
      tmr2_q <= 1'b0;
      uart2_q <= 1'b0;
      wdt_q <= 1'b0;
      ecc_q <= 1'b0;
      ext_q <= 7'h00;
      ext_prev_q <= 7'h00;
      gpio_q <= {NUM_PINS{1'b0}};
      gpio_prev_q <= {NUM_PINS{1'b0}};
    end else begin
      uart1_q <= UART1_IRQ_I;
      tmr2_q <= TIMER2_IRQ_I;
      uart2_q <= UART2_IRQ_I;
      wdt_q <= WATCHDOG_IRQ_I;
      ecc_q <= ECC_IRQ_I;
      ext_q <= EXT_IRQ_I;
      ext_prev_q <= ext_q;
      gpio_q <= GPIO_I;
      gpio_prev_q <= gpio_q;
    end
  end

  // ========================================================
  // Pin edge detection
  reg [NUM_PINS-1:0] pin_ev;
  reg pg0_ev, pg1_ev;
  always @* begin
    pg0_ev = 1'b0;
    pg1_ev = 1'b0;
    for (m = 0; m < NUM_PINS; m = m + 1) begin
      // Each pin picks rising, falling or both edges
      pin_ev[m] = (pincfg_q[m][`PIW_PINCFG_RISE] & gpio_q[m] &
                   ~gpio_prev_q[m]) |
                  (pincfg_q[m][`PIW_PINCFG_FALL] & ~gpio_q[m] &
                   gpio_prev_q[m]);
      if (pincfg_q[m][`PIW_PINCFG_GROUP]) begin
        pg1_ev = pg1_ev | pin_ev[m];
      end else begin
        pg0_ev = pg0_ev | pin_ev[m];
      end
    end
  end

  // ========================================================
  // Arbitration
  // Index order is natural order; sources 4..6 and 8..15 are plain mirrors
  wire [15:0] pend = {ecc_q, ext_q[6:4], wdt_q, ext_q[3:1], i2cm_q,
                      uart2_q, tmr2_q, uart1_q, tf1_q, pg1f_q,
                      tf0_q, pg0f_q};
  // Main and extended enable bits map straight onto the indices
  wire ea = ie_q[`PIW_IE_GLOBAL];
  wire [15:0] en = {1'b1, irq_enable_extended_q, ie_q[6:0]};
  wire [15:0] prio = {1'b0, irq_priority_extended_q, ip_q[6:0]};
  wire [15:0] elig = pend & en & {16{ea}};
  wire [15:0] hi_set = elig & prio;
  wire [15:0] lo_set = elig & ~prio;
  wire [4:0] hi_id = first_set(hi_set);
  wire [4:0] lo_id = first_set(lo_set);
  // A running routine blocks its own level and below
  wire allow_hi = ~hip_q & ~dbg_is_q;
  wire allow_lo = ~hip_q & ~lip_q & ~dbg_is_q;

  reg [4:0] win_id;
  reg [1:0] win_lvl;
  reg win_ok;
  reg [7:0] win_off;
  reg [3:0] nib;
  always @* begin
    win_ok = 1'b1;
    win_id = `PIW_ID_NONE;
    win_lvl = `PIW_LVL_LOW;
    // Debug sources bypass the global enable
    if (dbg_pend_q & ~dbg_is_q) begin
      win_id = `PIW_ID_DBG;
      win_lvl = `PIW_LVL_DBG;
    end else if (bkp_pend_q & ~dbg_is_q) begin
      win_id = `PIW_ID_BKP;
      win_lvl = `PIW_LVL_DBG;
    end else if (allow_hi && hi_id != `PIW_ID_NONE) begin
      win_id = hi_id;
      win_lvl = `PIW_LVL_HIGH;
    end else if (allow_lo && lo_id != `PIW_ID_NONE) begin
      win_id = lo_id;
    end else begin
      win_ok = 1'b0;
    end
    case (win_id)
      `PIW_ID_DBG: win_off = `PIW_VEC_DBG;
      `PIW_ID_BKP: win_off = `PIW_VEC_BKP;
      default: win_off = `PIW_VEC_FIRST + {win_id[3:0], 3'b000};
    endcase
    // Memory size code 0..3 gives region nibble 3, 7, B, F
    nib = {veccfg_q[1:0], 2'b11};
  end

  // Request and vector are held in flops for a clean CPU sample
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      IRQ_REQ_O <= 1'b0;
      IRQ_VECTOR_O <= 16'h0000;
      sel_q <= `PIW_ID_NONE;
      sel_lvl_q <= `PIW_LVL_LOW;
    end else begin
      IRQ_REQ_O <= win_ok & ~IRQ_ACK_I;
      sel_q <= win_id;
      sel_lvl_q <= win_lvl;
      if (veccfg_q[`PIW_VECCFG_RELOC]) begin
        IRQ_VECTOR_O <= {nib, 4'h0, win_off};
      end else begin
        IRQ_VECTOR_O <= {8'h00, win_off};
      end
    end
  end

  wire take = IRQ_ACK_I & IRQ_REQ_O;

  // ========================================================
  // Service tracking
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      dbg_is_q <= 1'b0;
      hip_q <= 1'b0;
      lip_q <= 1'b0;
    end else if (take) begin
      case (sel_lvl_q)
        `PIW_LVL_DBG: dbg_is_q <= 1'b1;
        `PIW_LVL_HIGH: hip_q <= 1'b1;
        default: lip_q <= 1'b1;
      endcase
    end else if (IRQ_RETURN_I) begin
      // Return closes the innermost routine first
      if (dbg_is_q) begin
        dbg_is_q <= 1'b0;
      end else if (hip_q) begin
        hip_q <= 1'b0;
      end else begin
        lip_q <= 1'b0;
      end
    end
  end

  // ========================================================
  // Flags; a hardware set always beats a clear
  wire wr_tpic = WR_I && ADDR_I == `PIW_ADDR_TPIC;
  wire wr_exf = WR_I && ADDR_I == `PIW_ADDR_EXFLAG;
  wire dbg_evt = DEBUG_PORT_MODE_I & DEBUG_REQ_I & DEBUG_ID_MATCH_I;

  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      tf0_q <= 1'b0;
      tf1_q <= 1'b0;
      pg0f_q <= 1'b0;
      pg1f_q <= 1'b0;
      i2cm_q <= 1'b0;
      dbg_pend_q <= 1'b0;
      bkp_pend_q <= 1'b0;
    end else begin
      // Entry clears timer and pin-group flags
      if (TIMER0_OVF_I) begin
        tf0_q <= 1'b1;
      end else if (take && sel_q == `PIW_ID_TF0) begin
        tf0_q <= 1'b0;
      end
      if (TIMER1_OVF_I) begin
        tf1_q <= 1'b1;
      end else if (take && sel_q == `PIW_ID_TF1) begin
        tf1_q <= 1'b0;
      end
      // Writing one leaves a flag alone; only zero clears
      if (pg0_ev) begin
        pg0f_q <= 1'b1;
      end else if ((take && sel_q == `PIW_ID_PG0) ||
                   (wr_tpic && !WR_DATA_I[`PIW_TPIC_PG0])) begin
        pg0f_q <= 1'b0;
      end
      if (pg1_ev) begin
        pg1f_q <= 1'b1;
      end else if ((take && sel_q == `PIW_ID_PG1) ||
                   (wr_tpic && !WR_DATA_I[`PIW_TPIC_PG1])) begin
        pg1f_q <= 1'b0;
      end
      // No clear on entry; the handler must write it to zero
      if (I2C_MASTER_EVT_I) begin
        i2cm_q <= 1'b1;
      end else if (wr_exf && !WR_DATA_I[0]) begin
        i2cm_q <= 1'b0;
      end
      if (dbg_evt) begin
        dbg_pend_q <= 1'b1;
      end else if (take && sel_q == `PIW_ID_DBG) begin
        dbg_pend_q <= 1'b0;
      end
      if (BREAKPOINT_MATCH_I) begin
        bkp_pend_q <= 1'b1;
      end else if (take && sel_q == `PIW_ID_BKP) begin
        bkp_pend_q <= 1'b0;
      end
    end
  end

  // ========================================================
  // Register writes
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      ie_q <= `PIW_RST_ZERO;
      ip_q <= `PIW_RST_ZERO;
      irq_enable_extended_q <= `PIW_RST_ZERO;
      irq_priority_extended_q <= `PIW_RST_ZERO;
      veccfg_q <= `PIW_RST_ZERO;
      wakeup_source_mask_q <= `PIW_RST_WAKEUP_SOURCE_MASK;
      tr0_q <= 1'b0;
      tr1_q <= 1'b0;
      for (i = 0; i < NUM_PINS; i = i + 1) begin
        pincfg_q[i] <= `PIW_RST_ZERO;
      end
    end else if (WR_I) begin
      case (ADDR_I)
        `PIW_ADDR_IEMAIN: ie_q <= WR_DATA_I;
        `PIW_ADDR_IPMAIN: ip_q <= {1'b0, WR_DATA_I[6:0]};
        `PIW_ADDR_IEEXT: irq_enable_extended_q <= WR_DATA_I;
        `PIW_ADDR_IPEXT: irq_priority_extended_q <= WR_DATA_I;
        `PIW_ADDR_WAKEUP_SOURCE_MASK: wakeup_source_mask_q <= WR_DATA_I;
        `PIW_ADDR_VECCFG: veccfg_q <= WR_DATA_I & 8'h23;
        `PIW_ADDR_TPIC: begin
          tr0_q <= WR_DATA_I[`PIW_TPIC_TR0];
          tr1_q <= WR_DATA_I[`PIW_TPIC_TR1];
        end
        default: begin
          for (i = 0; i < NUM_PINS; i = i + 1) begin
            if (ADDR_I == `PIW_ADDR_PINCFG + i[7:0]) begin
              pincfg_q[i] <= WR_DATA_I & 8'h07;
            end
          end
        end
      endcase
    end
  end

  assign TIMER0_RUN_O = tr0_q;
  assign TIMER1_RUN_O = tr1_q;

  // ========================================================
  // Register reads, data one cycle after the strobe
  reg [7:0] rd_d;
  always @* begin
    rd_d = 8'h00;
    case (ADDR_I)
      `PIW_ADDR_TPIC: rd_d = {tf1_q, tr1_q, tf0_q, tr0_q,
                              pg1f_q, 1'b0, pg0f_q, 1'b0};
      `PIW_ADDR_EXFLAG: rd_d = {ext_q[6:4], 1'b0, ext_q[3:1],
                                i2cm_q};
      `PIW_ADDR_WAKEUP_SOURCE_MASK: rd_d = wakeup_source_mask_q;
      `PIW_ADDR_IEMAIN: rd_d = ie_q;
      `PIW_ADDR_IPMAIN: rd_d = ip_q;
      `PIW_ADDR_IEEXT: rd_d = irq_enable_extended_q;
      `PIW_ADDR_IPEXT: rd_d = irq_priority_extended_q;
      `PIW_ADDR_VECCFG: rd_d = veccfg_q;
      `PIW_ADDR_STATUS: rd_d = {1'b0, hip_q, lip_q, 5'h00};
      default: begin
        for (j = 0; j < NUM_PINS; j = j + 1) begin
          if (ADDR_I == `PIW_ADDR_PINCFG + j[7:0]) begin
            rd_d = pincfg_q[j];
          end
        end
      end
    endcase
  end

  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      RD_DATA_O <= 8'h00;
    end else if (RD_I) begin
      RD_DATA_O <= rd_d;
    end
  end

  // ========================================================
  // Wake-up from STOP, wired apart from the enables
  // Level sources are edge-detected so a held level cannot loop
  wire [6:0] ext_rise = ext_q & ~ext_prev_q;
  wire [7:0] wake_src = {ext_rise[6:4], ext_rise[3:1], pg1_ev, pg0_ev};
  // Clocked peripherals are blocked even if their mask bit is set
  wire wake_hit = |(wake_src & wakeup_source_mask_q & CLOCKLESS_MASK);

  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      st_q <= ST_RUN;
      OSC_START_O <= 1'b0;
      CLK_RESUME_O <= 1'b0;
    end else begin
      CLK_RESUME_O <= 1'b0;
      case (st_q)
        ST_RUN: begin
          if (STOP_I && wake_hit) begin
            OSC_START_O <= 1'b1;
            st_q <= ST_OSC;
          end
        end
        ST_OSC: begin
          // Clock stays off until the oscillator reports ready
          if (OSC_READY_I) begin
            OSC_START_O <= 1'b0;
            st_q <= ST_RES;
          end
        end
        ST_RES: begin
          CLK_RESUME_O <= 1'b1;
          st_q <= ST_RUN;
        end
        default: begin
          OSC_START_O <= 1'b0;
          st_q <= ST_RUN;
        end
      endcase
    end
  end

endmodule // piw_ctrl

// ---- sim/piw_ctrl_asserts.sv ----
// Port-level assertions for the interrupt and wake-up controller
module piw_ctrl_asserts #(
  parameter NUM_PINS = 8,
  parameter [7:0] CLOCKLESS_MASK = 8'h0B
) (
  // Clock and reset
  input wire CLK_SYS_I,
  input wire RST_I,
  // Debug and CPU side
  input wire DEBUG_PORT_MODE_I,
  input wire DEBUG_REQ_I,
  input wire DEBUG_ID_MATCH_I,
  input wire IRQ_REQ_O,
  input wire [15:0] IRQ_VECTOR_O,
  input wire IRQ_ACK_I,
  // Power
  input wire STOP_I,
  input wire OSC_START_O,
  input wire OSC_READY_I,
  input wire CLK_RESUME_O
);
  timeunit 1ns;
  timeprecision 1ps;
  wire dbg_evt = DEBUG_PORT_MODE_I && DEBUG_REQ_I && DEBUG_ID_MATCH_I;
  wire [7:0] vlo = IRQ_VECTOR_O[7:0];
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);
  // ==========================================================
  // Vectoring
  a_ack_drops_req:
    assert property (IRQ_ACK_I && IRQ_REQ_O |=> !IRQ_REQ_O)
    else $error("request still up after entry");
  a_vector_slot:
    assert property (IRQ_REQ_O |-> (vlo[2:0] == 3'h3 && vlo <= 8'h7B)
      || vlo == 8'h80 || vlo == 8'hC0)
    else $error("vector outside the slot table");
  a_vector_region:
    assert property (IRQ_REQ_O |-> IRQ_VECTOR_O[11:8] == 4'h0 &&
      (IRQ_VECTOR_O[15:12] == 4'h0 || IRQ_VECTOR_O[13:12] == 2'b11))
    else $error("vector region nibble wrong");
  a_debug_wins:
    assert property (IRQ_REQ_O && vlo == 8'h80 |-> !$past(dbg_evt, 2))
    else $error("breakpoint presented over debug");
  // ==========================================================
  // Wake-up
  sequence s_osc_done;
    OSC_START_O && OSC_READY_I;
  endsequence
  sequence s_resume;
    !OSC_START_O ##1 CLK_RESUME_O ##1 !CLK_RESUME_O;
  endsequence
  a_wake_needs_stop:
    assert property ($rose(OSC_START_O) |-> $past(STOP_I))
    else $error("oscillator started outside stop");
  a_osc_holds:
    assert property (OSC_START_O && !OSC_READY_I |=> OSC_START_O)
    else $error("oscillator start dropped early");
  a_osc_then_resume:
    assert property (s_osc_done |=> s_resume)
    else $error("clock resume not after ready");
  a_resume_cause:
    assert property ($rose(CLK_RESUME_O) |->
      $past(OSC_START_O, 2) && !$past(OSC_START_O))
    else $error("clock resumed without oscillator");
endmodule // piw_ctrl_asserts

// ---- sim/piw_cpu_model.sv ----
// CPU entry logic and oscillator stand-in facing the controller
module piw_cpu_model (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Controller side
  input wire irq_req_i,
  input wire [15:0] irq_vector_i,
  input wire osc_start_i,
  output reg irq_ack_o,
  output reg osc_ready_o,
  // Bench control
  input wire ack_en_i,
  input wire [3:0] delay_i,
  output reg [15:0] last_vec_o,
  output reg [7:0] acks_o
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [3:0] wait_q;
  reg [3:0] osc_q;
  // ==========================================================
  // Entry: vector taken at the edge that samples the ack
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_ack_o <= 1'b0;
      wait_q <= 4'h0;
      acks_o <= 8'h00;
      last_vec_o <= 16'h0000;
    end else begin
      irq_ack_o <= 1'b0;
      if (irq_ack_o) begin
        last_vec_o <= irq_vector_i;
        acks_o <= acks_o + 8'h01;
      end
      if (irq_req_i && ack_en_i && !irq_ack_o) begin
        wait_q <= wait_q + 4'h1;
        if (wait_q >= delay_i) begin
          irq_ack_o <= 1'b1;
          wait_q <= 4'h0;
        end
      end else begin
        wait_q <= 4'h0;
      end
    end
  end
  // ==========================================================
  // Oscillator: ready only after a start-up delay, never early
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i || !osc_start_i) begin
      osc_q <= 4'h0;
      osc_ready_o <= 1'b0;
    end else if (osc_q == delay_i) begin
      osc_ready_o <= 1'b1;
    end else begin
      osc_q <= osc_q + 4'h1;
    end
  end
endmodule // piw_cpu_model

// ---- sim/priority_interrupt_wakeup_ctrl_tb_top.sv ----
// Self-checking bench for the priority interrupt and wake-up controller
module priority_interrupt_wakeup_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Stimulus and observation
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [7:0] gpio = 8'h00;
  reg t0 = 1'b0;
  reg t1 = 1'b0;
  reg i2c = 1'b0;
  reg ecc = 1'b0;
  reg wdt = 1'b0;
  reg [6:0] ext = 7'h00;
  reg dbg = 1'b0;
  reg breakpoint_irq = 1'b0;
  reg ret = 1'b0;
  reg stop = 1'b0;
  reg ack_en = 1'b0;
  reg [3:0] dly = 4'h0;
  reg [7:0] resumes = 8'h00;
  integer n_errors = 0;
  integer num_checks = 0;
  wire [7:0] rdata;
  wire req;
  wire ack;
  wire [15:0] vec;
  wire [15:0] last_vec;
  wire [7:0] acks;
  wire osc_start;
  wire osc_ready;
  wire resume;
  localparam [63:0] MAP_A = 64'h88919FA8B8E8F800;
  localparam [63:0] MAP_R = 64'h0000FF0000000000;
  piw_ctrl piw_ctrl_inst (
    .CLK_SYS_I(clk_sys), .RST_I(rst), .ADDR_I(addr), .WR_DATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RD_DATA_O(rdata), .GPIO_I(gpio),
    .TIMER0_OVF_I(t0), .TIMER1_OVF_I(t1), .UART1_IRQ_I(1'b0),
    .TIMER2_IRQ_I(1'b0), .UART2_IRQ_I(1'b0), .I2C_MASTER_EVT_I(i2c),
    .EXT_IRQ_I(ext), .WATCHDOG_IRQ_I(wdt), .ECC_IRQ_I(ecc),
    .DEBUG_PORT_MODE_I(dbg), .DEBUG_REQ_I(dbg), .DEBUG_ID_MATCH_I(dbg),
    .BREAKPOINT_MATCH_I(breakpoint_irq), .IRQ_REQ_O(req), .IRQ_VECTOR_O(vec),
    .IRQ_ACK_I(ack), .IRQ_RETURN_I(ret), .TIMER0_RUN_O(), .TIMER1_RUN_O(),
    .STOP_I(stop), .OSC_START_O(osc_start), .OSC_READY_I(osc_ready),
    .CLK_RESUME_O(resume));
  piw_cpu_model piw_cpu_model_inst (
    .clk_i(clk_sys), .rst_i(rst), .irq_req_i(req), .irq_vector_i(vec),
    .osc_start_i(osc_start), .irq_ack_o(ack), .osc_ready_o(osc_ready),
    .ack_en_i(ack_en), .delay_i(dly), .last_vec_o(last_vec), .acks_o(acks));
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (resume === 1'b1)
      resumes <= resumes + 8'h01;
  end
  // ==========================================================
  // Tasks
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr_reg(input [7:0] a, input [7:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task rd_reg(input [7:0] a, input [7:0] exp);
    begin
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(negedge clk_sys);
      chk({8'h00, rdata}, {8'h00, exp});
      @(posedge clk_sys);
    end
  endtask
  task fire(input a, input b);
    begin
      t0 <= a;
      t1 <= b;
      @(posedge clk_sys);
      t0 <= 1'b0;
      t1 <= 1'b0;
    end
  endtask
  // Waits for the next CPU entry and compares the vector it took
  task take(input [15:0] exp);
    integer i;
    reg [7:0] n;
    begin
      n = acks;
      for (i = 0; i < 40 && acks === n; i = i + 1)
        @(posedge clk_sys);
      if (acks === n) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: got %h exp %h", $time, last_vec, exp);
      end else begin
        @(negedge clk_sys);
        chk(last_vec, exp);
      end
      @(posedge clk_sys);
    end
  endtask
  task rtn;
    begin
      ret <= 1'b1;
      @(posedge clk_sys);
      ret <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  // Request must stay low; looked at mid-cycle, clear of the edge
  task chk_idle;
    begin
      @(negedge clk_sys);
      chk({15'h0000, req}, 16'h0000);
      @(posedge clk_sys);
    end
  endtask
  // Level stays up the whole window, so a second wake would show
  task wake(input [7:0] m, input [7:0] g, input [6:0] e, input [7:0] x);
    reg [7:0] n;
    begin
      wr_reg(8'h9F, m);
      stop <= 1'b1;
      n = resumes;
      gpio <= g;
      ext <= e;
      repeat (40) @(posedge clk_sys);
      chk({8'h00, resumes - n}, {8'h00, x});
      stop <= 1'b0;
      gpio <= 8'h00;
      ext <= 7'h00;
      repeat (4) @(posedge clk_sys);
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin : main
    integer k;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (k = 0; k < 8; k = k + 1)
      rd_reg(MAP_A[63-8*k -: 8], MAP_R[63-8*k -: 8]);
    for (k = 2; k < 7; k = k + 1) begin
      wr_reg(MAP_A[63-8*k -: 8], 8'h5A);
      rd_reg(MAP_A[63-8*k -: 8], 8'h5A);
      wr_reg(MAP_A[63-8*k -: 8], MAP_R[63-8*k -: 8]);
    end
    $display("test registers done");
    wr_reg(8'h88, 8'hFF);
    rd_reg(8'h88, 8'h50);
    wr_reg(8'h88, 8'h00);
    wr_reg(8'h91, 8'hFF);
    rd_reg(8'h91, 8'h00);
    ext <= 7'h7E;
    i2c <= 1'b1;
    @(posedge clk_sys);
    i2c <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rd_reg(8'h91, 8'hEF);
    wr_reg(8'h91, 8'h00);
    rd_reg(8'h91, 8'hEE);
    ext <= 7'h00;
    $display("test flags done");
    wr_reg(8'hA8, 8'h8A);
    ack_en <= 1'b1;
    for (k = 0; k < 2; k = k + 1) begin
      dly <= k ? 4'h3 : 4'h0;
      wr_reg(8'hB8, k ? 8'h00 : 8'h08);
      fire(1'b1, 1'b1);
      take(k ? 16'h000B : 16'h001B);
      repeat (4) @(posedge clk_sys);
      chk_idle;
      rd_reg(8'hC5, k ? 8'h20 : 8'h40);
      rtn;
      take(k ? 16'h001B : 16'h000B);
      rtn;
    end
    rd_reg(8'h88, 8'h00);
    wr_reg(8'hB8, 8'h08);
    fire(1'b1, 1'b0);
    take(16'h000B);
    fire(1'b0, 1'b1);
    take(16'h001B);
    rd_reg(8'hC5, 8'h60);
    rtn;
    rd_reg(8'hC5, 8'h20);
    rtn;
    wr_reg(8'hB8, 8'h00);
    ecc <= 1'b1;
    take(16'h007B);
    ecc <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rtn;
    wr_reg(8'hA8, 8'h88);
    fire(1'b1, 1'b0);
    repeat (4) @(posedge clk_sys);
    chk_idle;
    rd_reg(8'h88, 8'h20);
    wr_reg(8'hA8, 8'h8A);
    take(16'h000B);
    rtn;
    wr_reg(8'hE8, 8'h10);
    wdt <= 1'b1;
    take(16'h005B);
    wdt <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rtn;
    wr_reg(8'hE8, 8'h00);
    $display("test priority done");
    wr_reg(8'hA8, 8'h00);
    ack_en <= 1'b0;
    dbg <= 1'b1;
    breakpoint_irq <= 1'b1;
    @(posedge clk_sys);
    dbg <= 1'b0;
    breakpoint_irq <= 1'b0;
    repeat (3) @(posedge clk_sys);
    ack_en <= 1'b1;
    take(16'h00C0);
    rtn;
    take(16'h0080);
    rtn;
    for (k = 0; k < 4; k = k + 1) begin
      wr_reg(8'hC0, 8'h20 | k[7:0]);
      breakpoint_irq <= 1'b1;
      @(posedge clk_sys);
      breakpoint_irq <= 1'b0;
      take({k[1:0], 2'b11, 12'h080});
      rtn;
    end
    wr_reg(8'hC0, 8'h00);
    $display("test debug done");
    wr_reg(8'hD0, 8'h01);
    wake(8'hFF, 8'h01, 7'h00, 8'h01);
    chk_idle;
    rd_reg(8'h88, 8'h02);
    wr_reg(8'h88, 8'h00);
    wr_reg(8'hD1, 8'h07);
    wake(8'hFF, 8'h02, 7'h00, 8'h01);
    rd_reg(8'h88, 8'h08);
    wake(8'hFE, 8'h01, 7'h00, 8'h00);
    wake(8'hFF, 8'h00, 7'h04, 8'h01);
    wake(8'hFF, 8'h00, 7'h10, 8'h00);
    $display("test wake done");
    print_verdict;
  end
endmodule // priority_interrupt_wakeup_ctrl_tb_top
bind piw_ctrl piw_ctrl_asserts #(
  .NUM_PINS(NUM_PINS), .CLOCKLESS_MASK(CLOCKLESS_MASK)
) piw_ctrl_asserts_inst (
  .CLK_SYS_I, .RST_I, .DEBUG_PORT_MODE_I, .DEBUG_REQ_I,
  .DEBUG_ID_MATCH_I, .IRQ_REQ_O, .IRQ_VECTOR_O, .IRQ_ACK_I, .STOP_I,
  .OSC_START_O, .OSC_READY_I, .CLK_RESUME_O);
